// file: lpmc_pkg.sv
// Shared constants and types for the transceiver mode and path controller.
package lpmc_pkg;
	localparam int CLK_PERIOD_NS = 20;
	localparam int TIMER_W = 13;
	localparam int DATA_W = 8;
	localparam int FIFO_DEPTH = 16;
	localparam int FRAME_BITS = 10;
	// Toggle step time, held above the 12.5 us minimum.
	localparam int T_STEP_NS = 13000;
	localparam int T_TOGGLE_MAX_NS = 45000;
	localparam int T_RXD_CHECK_NS = 10000;
	localparam int T_FIRST_DOM_NS = 80000;
	localparam int T_SLEEP_NS = 91000;
	localparam int T_DOM_MIN_NS = 3750000;
	localparam int T_BIT_NS = 50000;
	localparam int T_FAST_BIT_NS = 10000;
	localparam int STEP_CYC = (T_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TOGGLE_MAX_CYC = T_TOGGLE_MAX_NS / CLK_PERIOD_NS;
	localparam int RXD_CHECK_CYC = (T_RXD_CHECK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FIRST_DOM_CYC = (T_FIRST_DOM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SLEEP_CYC_DEF = (T_SLEEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DOM_MIN_CYC_DEF = T_DOM_MIN_NS / CLK_PERIOD_NS;
	localparam int BIT_CYC = T_BIT_NS / CLK_PERIOD_NS;
	localparam int FAST_BIT_CYC = T_FAST_BIT_NS / CLK_PERIOD_NS;
	localparam logic [3:0] FRAME_BITS_V = 4'hA;
	localparam logic [3:0] BITS_NONE = 4'h0;
	localparam logic [TIMER_W-1:0] TIMER_ZERO = 13'h0000;
	localparam logic LVL_DOMINANT = 1'b0;
	localparam logic LVL_RECESSIVE = 1'b1;
	typedef enum logic [2:0] {
		S_SLEEP,
		S_PREP,
		S_FIRST,
		S_NORMAL,
		S_TOG_PRE,
		S_TOG_LOW,
		S_TOG_POST,
		S_TOG_CHK
	} lpmc_state_t;
endpackage : lpmc_pkg

// file: lpmc_fifo.sv
// Transmit byte FIFO with valid and ready on both sides.
`timescale 1ns/10ps
module lpmc_fifo
	import lpmc_pkg::*;
#(
	parameter int WIDTH = DATA_W,
	parameter int DEPTH = FIFO_DEPTH
)(
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic in_valid_in,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic in_ready_out,
	output logic out_valid_out,
	output logic [WIDTH-1:0] out_data_out,
	input wire logic out_ready_in
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
	localparam logic [AW:0] ONE_CNT = (AW+1)'(1);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic [AW:0] cnt_d;
	logic push;
	logic pop;

	assign push = in_valid_in && in_ready_out;
	assign pop = out_valid_out && out_ready_in;
	assign out_valid_out = cnt_q != '0;
	assign out_data_out = mem_q[rd_q];

	always_comb
	begin
		cnt_d = cnt_q;
		if (push && !pop)
			cnt_d = cnt_q + ONE_CNT;
		else if (pop && !push)
			cnt_d = cnt_q - ONE_CNT;
	end

	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			cnt_q <= '0;
			wr_q <= '0;
			rd_q <= '0;
			in_ready_out <= 1'b1;
		end
		else
		begin
			cnt_q <= cnt_d;
			in_ready_out <= cnt_d != FULL_CNT;
			if (push)
				wr_q <= wr_q + AW'(1);
			if (pop)
				rd_q <= rd_q + AW'(1);
		end
	end

	always_ff @(posedge clock_in)
	begin
		if (push)
			mem_q[wr_q] <= in_data_in;
	end

	fifo_bound_a: assert property (@(posedge clock_in) disable iff (rst_in) cnt_q <= FULL_CNT)
		else $error("FIFO count above depth.");
endmodule : lpmc_fifo

// file: lpmc_host.sv
// Host controller that drives the transceiver mode-select and transmit pins and reads receive-data.
`timescale 1ns/10ps
module lpmc_host
	import lpmc_pkg::*;
#(
	parameter int SLEEP_CYC = SLEEP_CYC_DEF,
	parameter int DOM_MIN_CYC = DOM_MIN_CYC_DEF
)(
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic cmd_normal_in,
	input wire logic cmd_sleep_in,
	input wire logic cmd_toggle_in,
	input wire logic tx_valid_in,
	input wire logic [DATA_W-1:0] tx_data_in,
	output logic tx_ready_out,
	input wire logic rxd_in,
	output logic mode_select_out,
	output logic txd_out,
	output logic rx_bit_out,
	output logic fast_baud_out,
	output logic asleep_out,
	output logic wake_out,
	output logic busy_out
);
	lpmc_state_t st_q;
	logic [TIMER_W-1:0] timer_q;
	logic [3:0] bits_q;
	logic [FRAME_BITS-1:0] shift_q;
	logic rx_q;
	logic saw_low_q;
	logic fifo_valid;
	logic [DATA_W-1:0] fifo_data;
	logic load;
	logic tx_idle;
	logic [TIMER_W-1:0] bit_len;

	assign tx_idle = bits_q == BITS_NONE;
	assign load = st_q == S_NORMAL && tx_idle && fifo_valid && !cmd_sleep_in && !cmd_toggle_in;
	assign bit_len = fast_baud_out ? TIMER_W'(FAST_BIT_CYC - 1) : TIMER_W'(BIT_CYC - 1);

	lpmc_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clock_in(clock_in),
		.rst_in(rst_in),
		.in_valid_in(tx_valid_in),
		.in_data_in(tx_data_in),
		.in_ready_out(tx_ready_out),
		.out_valid_out(fifo_valid),
		.out_data_out(fifo_data),
		.out_ready_in(load)
	);

	// Mode sequencing; every wait is a cycle count on the system clock.
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			st_q <= S_SLEEP;
			timer_q <= TIMER_ZERO;
			mode_select_out <= 1'b0;
			asleep_out <= 1'b1;
		end
		else
		begin
			if (timer_q != TIMER_ZERO)
				timer_q <= timer_q - TIMER_W'(1);
			case (st_q)
				S_SLEEP:
					if (cmd_normal_in)
					begin
						st_q <= S_FIRST;
						mode_select_out <= 1'b1;
						asleep_out <= 1'b0;
						timer_q <= TIMER_W'(FIRST_DOM_CYC - 1);
					end
				S_PREP:
					if (timer_q == TIMER_ZERO)
					begin
						st_q <= S_SLEEP;
						asleep_out <= 1'b1;
					end
				S_FIRST:
					if (timer_q == TIMER_ZERO)
						st_q <= S_NORMAL;
				S_NORMAL:
				begin
					if (load)
						timer_q <= bit_len;
					else if (tx_idle && cmd_sleep_in)
					begin
						st_q <= S_PREP;
						mode_select_out <= 1'b0;
						timer_q <= TIMER_W'(SLEEP_CYC - 1);
					end
					else if (tx_idle && cmd_toggle_in)
					begin
						st_q <= S_TOG_PRE;
						mode_select_out <= 1'b0;
						timer_q <= TIMER_W'(STEP_CYC - 1);
					end
					else if (!tx_idle && timer_q == TIMER_ZERO && bits_q != 4'h1)
						timer_q <= bit_len;
				end
				S_TOG_PRE:
					if (timer_q == TIMER_ZERO)
					begin
						st_q <= S_TOG_LOW;
						timer_q <= TIMER_W'(STEP_CYC - 1);
					end
				S_TOG_LOW:
					if (timer_q == TIMER_ZERO)
					begin
						st_q <= S_TOG_POST;
						// One cycle longer, because transmit-data rises a cycle after this state begins.
						timer_q <= TIMER_W'(STEP_CYC);
					end
				S_TOG_POST:
					if (timer_q == TIMER_ZERO)
					begin
						st_q <= S_TOG_CHK;
						mode_select_out <= 1'b1;
						timer_q <= TIMER_W'(RXD_CHECK_CYC - 1);
					end
				S_TOG_CHK:
					if (timer_q == TIMER_ZERO)
						st_q <= S_NORMAL;
				default:
					st_q <= S_SLEEP;
			endcase
		end
	end

	// Frame serializer: start bit, eight data bits LSB first, stop bit.
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			bits_q <= BITS_NONE;
			shift_q <= '1;
			txd_out <= LVL_RECESSIVE;
		end
		else if (load)
		begin
			bits_q <= FRAME_BITS_V;
			shift_q <= {LVL_RECESSIVE, fifo_data, LVL_DOMINANT};
			txd_out <= LVL_DOMINANT;
		end
		else if (st_q == S_TOG_LOW)
			txd_out <= LVL_DOMINANT;
		else if (st_q == S_NORMAL && !tx_idle && timer_q == TIMER_ZERO)
		begin
			bits_q <= bits_q - 4'h1;
			shift_q <= {LVL_RECESSIVE, shift_q[FRAME_BITS-1:1]};
			txd_out <= (bits_q == 4'h1) ? LVL_RECESSIVE : shift_q[1];
		end
		else if (st_q != S_NORMAL)
			txd_out <= LVL_RECESSIVE;
	end

	// Receive sampling, wake capture and fast baud confirmation.
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			rx_q <= LVL_RECESSIVE;
			rx_bit_out <= LVL_RECESSIVE;
			saw_low_q <= 1'b0;
			fast_baud_out <= 1'b0;
			wake_out <= 1'b0;
		end
		else
		begin
			rx_q <= rxd_in;
			if (mode_select_out)
				rx_bit_out <= rx_q;
			if (st_q == S_TOG_POST)
				saw_low_q <= 1'b0;
			else if (st_q == S_TOG_CHK && rx_q == LVL_DOMINANT)
				saw_low_q <= 1'b1;
			if (st_q == S_TOG_CHK && timer_q == TIMER_ZERO)
				fast_baud_out <= saw_low_q;
			else if (st_q == S_PREP)
				fast_baud_out <= 1'b0;
			// The wake report still sits on the pin at the accepting edge, so the flag clears once awake.
			if (asleep_out && rx_q == LVL_DOMINANT)
				wake_out <= 1'b1;
			else if (st_q == S_FIRST)
				wake_out <= 1'b0;
		end
	end

	always_ff @(posedge clock_in)
	begin
		if (rst_in)
			busy_out <= 1'b1;
		else
			busy_out <= !(st_q == S_NORMAL && tx_idle && !load) && !(st_q == S_SLEEP && !cmd_normal_in);
	end

	logic [TIMER_W-1:0] en_low_cnt;
	logic [TIMER_W-1:0] awake_cnt;
	logic [TIMER_W-1:0] txd_high_cnt;
	logic [TIMER_W-1:0] txd_low_tog;
	logic [17:0] txd_low_cnt;

	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			en_low_cnt <= TIMER_ZERO;
			awake_cnt <= TIMER_ZERO;
			txd_high_cnt <= TIMER_ZERO;
			txd_low_tog <= TIMER_ZERO;
			txd_low_cnt <= '0;
		end
		else
		begin
			en_low_cnt <= mode_select_out ? TIMER_ZERO : (&en_low_cnt ? en_low_cnt : en_low_cnt + TIMER_W'(1));
			awake_cnt <= asleep_out ? TIMER_ZERO : (&awake_cnt ? awake_cnt : awake_cnt + TIMER_W'(1));
			txd_high_cnt <= !txd_out ? TIMER_ZERO : (&txd_high_cnt ? txd_high_cnt : txd_high_cnt + TIMER_W'(1));
			txd_low_tog <= txd_out ? TIMER_ZERO : (&txd_low_tog ? txd_low_tog : txd_low_tog + TIMER_W'(1));
			txd_low_cnt <= txd_out ? '0 : (&txd_low_cnt ? txd_low_cnt : txd_low_cnt + 18'h00001);
		end
	end

	sequence tog_release_s;
		st_q == S_TOG_POST ##1 st_q == S_TOG_CHK;
	endsequence

	toggle_len_a: assert property (@(posedge clock_in) disable iff (rst_in)
		$rose(mode_select_out) && st_q == S_TOG_CHK |-> en_low_cnt <= TIMER_W'(TOGGLE_MAX_CYC))
		else $error("Toggle held mode-select low too long.");
	tog_low_a: assert property (@(posedge clock_in) disable iff (rst_in)
		$rose(txd_out) && !mode_select_out |-> txd_low_tog >= TIMER_W'(STEP_CYC))
		else $error("Toggle transmit low pulse too short.");
	pre_high_a: assert property (@(posedge clock_in) disable iff (rst_in)
		$fell(txd_out) && !mode_select_out |-> en_low_cnt >= TIMER_W'(STEP_CYC))
		else $error("Transmit fell too soon after mode-select fell.");
	post_high_a: assert property (@(posedge clock_in) disable iff (rst_in)
		tog_release_s |-> txd_high_cnt >= TIMER_W'(STEP_CYC))
		else $error("Mode-select rose too soon after transmit rose.");
	chk_window_a: assert property (@(posedge clock_in) disable iff (rst_in)
		tog_release_s |-> mode_select_out throughout (##[1:600] st_q == S_NORMAL))
		else $error("Fast baud check window not closed in time.");
	fast_cause_a: assert property (@(posedge clock_in) disable iff (rst_in)
		$rose(fast_baud_out) |-> $past(st_q) == S_TOG_CHK && $past(saw_low_q))
		else $error("Fast baud set without a receive low pulse.");
	first_dom_a: assert property (@(posedge clock_in) disable iff (rst_in)
		mode_select_out && !txd_out |-> awake_cnt >= TIMER_W'(FIRST_DOM_CYC))
		else $error("Dominant sent inside first-dominant delay.");
	dom_limit_a: assert property (@(posedge clock_in) disable iff (rst_in)
		txd_low_cnt < 18'(DOM_MIN_CYC))
		else $error("Transmit held dominant past timeout.");
	sleep_quiet_a: assert property (@(posedge clock_in) disable iff (rst_in)
		asleep_out |-> txd_out && !mode_select_out)
		else $error("Bus or mode-select active while asleep.");
	wake_catch_a: assert property (@(posedge clock_in) disable iff (rst_in)
		asleep_out && rx_q == LVL_DOMINANT |=> wake_out)
		else $error("Wake report missed.");
endmodule : lpmc_host

// file: lpmc_xcvr_model.sv
// Behavioural transceiver model seen from the controller's pins.
`timescale 1ns/10ps
module lpmc_xcvr_model #(
	parameter int SD_CYC = 3500,
	parameter int FIRST_CYC = 2500,
	parameter int DOM_CYC = 187500,
	parameter int WUF_CYC = 2500,
	parameter int STEP_CYC = 625,
	parameter int TOG_CYC = 2250,
	parameter int PULSE_CYC = 200
)(
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic mode_select_in,
	input wire logic txd_in,
	input wire logic remote_dom_in,
	input wire logic fault_in,
	output logic rxd_out,
	output logic bus_out,
	output logic inhibit_out,
	output logic fast_out
);
	logic sleep_q, wake_q, en_q, txd_q, drive_dom, tog_ok;
	int lo_q, fall_q, rise_q, falls_q, first_q, dom_q, wuf_q, pulse_q;
	assign drive_dom = mode_select_in && !txd_in && first_q == 0 && dom_q < DOM_CYC && !fault_in;
	assign bus_out = !(drive_dom || remote_dom_in);
	assign rxd_out = sleep_q ? (wake_q ? 1'b0 : 1'bz) : (pulse_q != 0 || (!fault_in && !bus_out)) ? 1'b0 : 1'b1;
	assign inhibit_out = !sleep_q && !fault_in;
	assign tog_ok = falls_q == 1 && fall_q >= STEP_CYC && rise_q - fall_q >= STEP_CYC && lo_q - rise_q >= STEP_CYC;
	always @(posedge clock_in)
	begin
		en_q <= mode_select_in;
		txd_q <= txd_in;
		pulse_q <= (pulse_q != 0) ? pulse_q - 1 : 0;
		first_q <= (first_q != 0) ? first_q - 1 : 0;
		dom_q <= (mode_select_in && !txd_in) ? dom_q + 1 : 0;
		wuf_q <= remote_dom_in ? wuf_q + 1 : 0;
		if (rst_in)
		begin
			{sleep_q, wake_q, fast_out} <= 3'h4;
			lo_q <= 0;
			pulse_q <= 0;
			first_q <= 0;
			falls_q <= 0;
		end
		else if (mode_select_in)
		begin
			lo_q <= 0;
			falls_q <= 0;
			{sleep_q, wake_q} <= 2'h0;
			if (!en_q && sleep_q)
				first_q <= FIRST_CYC;
			if (!en_q && !sleep_q && lo_q <= TOG_CYC && tog_ok)
			begin
				fast_out <= !fast_out;
				if (!fast_out)
					pulse_q <= PULSE_CYC;
			end
		end
		else
		begin
			lo_q <= lo_q + 1;
			if (txd_q && !txd_in)
			begin
				falls_q <= falls_q + 1;
				fall_q <= lo_q;
			end
			if (!txd_q && txd_in)
				rise_q <= lo_q;
			if (lo_q == SD_CYC)
				{sleep_q, fast_out} <= 2'h2;
			if (sleep_q && !remote_dom_in && wuf_q > WUF_CYC)
				wake_q <= 1'b1;
		end
	end
endmodule : lpmc_xcvr_model

// file: lpmc_host_test.sv
// Self-checking bench for the mode and path controller against the transceiver model.
`timescale 1ns/10ps
module lpmc_host_test
	import lpmc_pkg::*;
;
	logic clock_in, rst_in, cmd_normal_in, cmd_sleep_in, cmd_toggle_in, tx_valid_in, remote_dom, mon_en;
	logic [DATA_W-1:0] tx_data_in;
	logic tx_ready_out, mode_select_out, txd_out, rx_bit_out, fast_baud_out, asleep_out, wake_out, busy_out;
	logic bus_lvl, inhibit, model_fast;
	tri1 rxd_w;
	int miscompares, checks, n, k;
	logic [DATA_W-1:0] exp_q[$];
	logic [9:0] frame;
	lpmc_host dut (.clock_in(clock_in), .rst_in(rst_in), .cmd_normal_in(cmd_normal_in),
		.cmd_sleep_in(cmd_sleep_in), .cmd_toggle_in(cmd_toggle_in), .tx_valid_in(tx_valid_in),
		.tx_data_in(tx_data_in), .tx_ready_out(tx_ready_out), .rxd_in(rxd_w), .mode_select_out(mode_select_out),
		.txd_out(txd_out), .rx_bit_out(rx_bit_out), .fast_baud_out(fast_baud_out), .asleep_out(asleep_out),
		.wake_out(wake_out), .busy_out(busy_out));
	lpmc_xcvr_model xcvr (.clock_in(clock_in), .rst_in(rst_in), .mode_select_in(mode_select_out),
		.txd_in(txd_out), .remote_dom_in(remote_dom), .fault_in(1'b0), .rxd_out(rxd_w), .bus_out(bus_lvl),
		.inhibit_out(inhibit), .fast_out(model_fast));
	task automatic end_sim();
		if (miscompares == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_sim
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wait_for(input int which, input int lim);
		int i;
		for (i = 0; i < lim; i++)
		begin
			@(posedge clock_in);
			if (which == 0 ? busy_out === 1'b0 : which == 1 ? asleep_out === 1'b1 : exp_q.size() == 0)
				return;
		end
		miscompares++;
		$display("mismatch at %0t: wait %0d timed out", $time, which);
		end_sim();
	endtask : wait_for
	task automatic pulse(input int which);
		@(posedge clock_in);
		cmd_normal_in <= (which == 0);
		cmd_sleep_in <= (which == 1);
		cmd_toggle_in <= (which == 2);
		@(posedge clock_in);
		{cmd_normal_in, cmd_sleep_in, cmd_toggle_in} <= 3'h0;
		@(posedge clock_in);
	endtask : pulse
	task automatic push(input logic [7:0] b);
		int i;
		tx_valid_in <= 1'b1;
		tx_data_in <= b;
		for (i = 0; i < 6000; i++)
		begin
			@(posedge clock_in);
			if (tx_ready_out === 1'b1)
				break;
		end
		if (i == 6000)
		begin
			miscompares++;
			$display("mismatch at %0t: push timed out", $time);
			end_sim();
		end
		exp_q.push_back(b);
	endtask : push
	initial
	begin
		clock_in = 1'b0;
		forever #10 clock_in = ~clock_in;
	end
	// Frames are decoded from the receive echo, so the whole loop through the bus is covered.
	initial
	begin
		forever
		begin
			@(posedge clock_in);
			if (mon_en && rx_bit_out === 1'b0)
			begin
				repeat (FAST_BIT_CYC / 2) @(posedge clock_in);
				for (k = 0; k < FRAME_BITS; k++)
				begin
					frame[k] = rx_bit_out;
					if (k < FRAME_BITS - 1)
						repeat (FAST_BIT_CYC) @(posedge clock_in);
				end
				chk({6'h00, frame[9], frame[0]}, 8'h02);
				chk(frame[8:1], exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
			end
		end
	end
	initial
	begin
		{rst_in, cmd_normal_in, cmd_sleep_in, cmd_toggle_in, tx_valid_in, remote_dom, mon_en} = 7'h40;
		tx_data_in = 8'h00;
		n = $urandom(32'h2de3);
		repeat (10) @(posedge clock_in);
		rst_in <= 1'b0;
		repeat (2) @(posedge clock_in);
		chk({5'h00, asleep_out, mode_select_out, txd_out}, 8'h05);
		chk({7'h00, inhibit}, 8'h00);
		remote_dom <= 1'b1;
		repeat (3000) @(posedge clock_in);
		remote_dom <= 1'b0;
		repeat (5) @(posedge clock_in);
		chk({7'h00, wake_out}, 8'h01);
		pulse(0);
		chk({7'h00, mode_select_out}, 8'h01);
		remote_dom <= 1'b1;
		repeat (6) @(posedge clock_in);
		chk({7'h00, rx_bit_out}, 8'h00);
		remote_dom <= 1'b0;
		wait_for(0, 6000);
		chk({6'h00, wake_out, rx_bit_out}, 8'h01);
		pulse(2);
		wait_for(0, 4000);
		chk({6'h00, fast_baud_out, model_fast}, 8'h03);
		mon_en <= 1'b1;
		for (n = 0; n < 17; n++)
			push(8'($urandom));
		tx_data_in <= 8'($urandom);
		repeat (3) @(posedge clock_in);
		chk({7'h00, tx_ready_out}, 8'h00);
		tx_valid_in <= 1'b0;
		wait_for(2, 90000);
		repeat (300) @(posedge clock_in);
		mon_en <= 1'b0;
		wait_for(0, 1000);
		pulse(2);
		wait_for(0, 4000);
		chk({6'h00, fast_baud_out, model_fast}, 8'h00);
		pulse(1);
		wait_for(1, 6000);
		chk({6'h00, inhibit, mode_select_out}, 8'h00);
		remote_dom <= 1'b1;
		repeat (100) @(posedge clock_in);
		remote_dom <= 1'b0;
		repeat (10) @(posedge clock_in);
		chk({7'h00, wake_out}, 8'h00);
		end_sim();
	end
endmodule : lpmc_host_test
